// file: logic/hcp_config_loader.sv
// hub configuration image loader and decoder
//
// Overview of operation
// - report power-good delay byte, 2 ms units, default 0x32
// - flag bit 7 set: accept hub descriptor type 0x00 as 0x29
// - flag bit 7 clear: stall hub descriptor request of type zero
// - flag bit 6 is combined-unit, shown in hub characteristics b2
// - flag bit 5 set: full speed only, never high speed
// - flag bit 4 set: indicators off and characteristics b7 clear
// - flag bit 2 selects common or per-port power, shown in b4 b3 b1 b0
// - byte 0 equal 0xd4 alone selects the extended layout
// - vendor and product ids from bytes 1-4, release high from byte 6
// - byte 7 nibbles set overcurrent filter ms, active and idle ports
// - extended layout, full speed: upstream current budget from byte 8, 2 mA units
// - extended layout, high speed: upstream current budget from byte 9, 2 mA units
// - extended layout, bus powered full speed: controller current from byte 12
// - extended layout, bus powered high speed: controller current from byte 13
// - extended layout, self powered: controller current from bytes 14 and 15
// - manufacturer pointers start at 24 plus twice language count
// - erased first byte 0xff: enumerate as vendor class device
// - usable ports numbered logically, detachable bits per logical port
module hcp_config_loader #(
	parameter int MS_CYCLES = hcp_pkg::MS_CYCLES,
	// identity defaults, values arbitrary
	parameter logic [15:0] DEF_VID = 16'h0001,
	parameter logic [15:0] DEF_PID = 16'h0002,
	parameter logic [7:0] DEF_REL_HI = 8'h01
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// image byte reader
	output logic o_rd_req,
	output logic [10:0] o_rd_addr,
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_data,
	// register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// hub state from the hub logic
	input wire logic i_hs_attached,
	input wire logic i_self_powered,
	input wire logic [3:0] i_port_enabled,
	input wire logic [3:0] i_port_pwr_req,
	input wire logic [3:0] i_ind_req,
	// hub descriptor request check
	input wire logic i_desc_req,
	input wire logic [7:0] i_desc_type,
	output logic o_desc_ok,
	output logic o_desc_stall,
	// overcurrent pins, active high
	input wire logic [3:0] i_port_oc,
	output logic [3:0] o_oc_flag,
	// port drive
	output logic [3:0] o_port_pwr,
	output logic [3:0] o_ind,
	// loaded descriptor fields
	output logic o_connect_en,
	output logic o_vendor_mode,
	output logic o_fs_restrict,
	output logic [7:0] o_power_good_delay,
	output logic [15:0] o_hub_char,
	output logic [15:0] o_vid,
	output logic [15:0] o_pid,
	output logic [7:0] o_release_hi,
	output logic [7:0] o_upstream_current_budget,
	output logic [7:0] o_controller_current,
	output logic [2:0] o_port_count,
	output logic [3:0] o_detachable_phys,
	output logic [4:0] o_language_count,
	output logic [7:0] o_string_bitmap,
	output logic [10:0] o_mfr_ptr_base
);
	typedef struct packed {
		hcp_pkg::hcp_load_state_type state;
		hcp_pkg::hcp_fmt_type fmt;
		logic reload;
		logic [4:0] addr;
		logic [hcp_pkg::IMG_BYTES-1:0][7:0] img;
		logic [15:0] ms_cnt;
		logic tick_ms;
		logic rd_req;
		logic connect_en;
		logic vendor_mode;
		logic desc_ok;
		logic desc_stall;
		logic [31:0] rdata;
		logic fs_restrict;
		logic [7:0] pwron;
		logic [15:0] hub_char;
		logic [15:0] vid;
		logic [15:0] pid;
		logic [7:0] rel_hi;
		logic [7:0] budget;
		logic [7:0] ctrl_cur;
		logic [2:0] port_count;
		logic [3:0] detach_phys;
		logic [4:0] langs;
		logic [7:0] bitmap;
		logic [10:0] mfr_base;
		logic [3:0] port_pwr;
		logic [3:0] ind;
	} hcp_ldr_state_type;

	hcp_ldr_state_type st;
	hcp_ldr_state_type next_st;
	logic [1:0] rst_pipe;
	logic rst_n;
	logic [3:0] oc_sync;
	// decoded values
	logic [7:0] flags;
	logic [7:0] oc_byte;
	logic [3:0] usable;
	logic [3:0] detach_log;
	logic [4:0] last_idx;
	logic hs;
	logic [2:0] lcnt;

	// reset release through two flops
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// overcurrent pins into the clock domain
	hcp_sync2 #(.W(4)) u_oc_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_async(i_port_oc),
		.o_sync(oc_sync)
	);

	// per-port overcurrent filters
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_oc
			hcp_oc_filter u_filter (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(rst_n),
				.i_tick_ms(st.tick_ms),
				.i_enabled(i_port_enabled[gp]),
				.i_limit_active(oc_byte[7:4]),
				.i_limit_idle(oc_byte[3:0]),
				.i_oc(oc_sync[gp]),
				.o_oc_flag(o_oc_flag[gp])
			);
		end
	endgenerate

	// next state: sequencer, decode, register port
	always_comb begin
		next_st = st;
		// one-cycle pulses default low
		next_st.desc_ok = 1'b0;
		next_st.desc_stall = 1'b0;
		next_st.rdata = 32'h0;

		// millisecond enable
		next_st.tick_ms = 1'b0;
		if (st.ms_cnt == 16'(MS_CYCLES - 1)) begin
			next_st.ms_cnt = 16'h0;
			next_st.tick_ms = 1'b1;
		end else begin
			next_st.ms_cnt = st.ms_cnt + 16'h1;
		end

		// last byte wanted for the layout found
		case (st.fmt)
			hcp_pkg::FMT_MIN: last_idx = hcp_pkg::LAST_MIN;
			hcp_pkg::FMT_MID: last_idx = hcp_pkg::LAST_MID;
			hcp_pkg::FMT_EXT: last_idx = hcp_pkg::LAST_EXT;
			default: last_idx = hcp_pkg::IDX_CODE;
		endcase

		// image fetch sequencer
		case (st.state)
			hcp_pkg::ST_IDLE: begin
				if (st.reload) begin
					next_st.reload = 1'b0;
					next_st.addr = hcp_pkg::IDX_CODE;
					next_st.fmt = hcp_pkg::FMT_NONE;
					next_st.vendor_mode = 1'b0;
					next_st.rd_req = 1'b1;
					next_st.state = hcp_pkg::ST_WAIT;
				end
			end
			hcp_pkg::ST_REQ: begin
				next_st.rd_req = 1'b1;
				next_st.state = hcp_pkg::ST_WAIT;
			end
			hcp_pkg::ST_WAIT: begin
				if (i_rd_valid) begin
					next_st.rd_req = 1'b0;
					next_st.img[st.addr] = i_rd_data;
					next_st.state = hcp_pkg::ST_REQ;
					next_st.addr = st.addr + 5'h1;
					if (st.addr == hcp_pkg::IDX_CODE) begin
						if (i_rd_data == hcp_pkg::CODE_ERASED) begin
							next_st.vendor_mode = 1'b1;
							next_st.state = hcp_pkg::ST_DONE;
						end else if (i_rd_data == hcp_pkg::CODE_EXT) begin
							next_st.fmt = hcp_pkg::FMT_EXT;
						end else if (i_rd_data == hcp_pkg::CODE_MID) begin
							next_st.fmt = hcp_pkg::FMT_MID;
						end else if (i_rd_data == hcp_pkg::CODE_MIN) begin
							next_st.fmt = hcp_pkg::FMT_MIN;
						end else begin
							next_st.state = hcp_pkg::ST_DONE;
						end
					end else if (st.addr == last_idx) begin
						next_st.state = hcp_pkg::ST_DONE;
					end
				end
			end
			default: begin
				if (st.reload) begin
					next_st.state = hcp_pkg::ST_IDLE;
				end
			end
		endcase
		// upstream only after the image is decoded
		next_st.connect_en = (st.state == hcp_pkg::ST_DONE) && !st.reload;

		// delay and flag bytes by layout
		case (st.fmt)
			hcp_pkg::FMT_EXT: begin
				next_st.pwron = st.img[hcp_pkg::IDX_EXT_PWRON];
				flags = st.img[hcp_pkg::IDX_EXT_FLAGS];
			end
			hcp_pkg::FMT_MID: begin
				next_st.pwron = st.img[hcp_pkg::IDX_MID_PWRON];
				flags = st.img[hcp_pkg::IDX_MID_FLAGS];
			end
			default: begin
				next_st.pwron = hcp_pkg::DEF_PWRON;
				flags = hcp_pkg::DEF_FLAGS;
			end
		endcase
		oc_byte = (st.fmt == hcp_pkg::FMT_EXT || st.fmt == hcp_pkg::FMT_MID)
			? st.img[hcp_pkg::IDX_OC] : hcp_pkg::DEF_OC;

		if (st.fmt != hcp_pkg::FMT_NONE) begin
			next_st.vid = {st.img[hcp_pkg::IDX_VID_HI],
				st.img[hcp_pkg::IDX_VID_LO]};
			next_st.pid = {st.img[hcp_pkg::IDX_PID_HI],
				st.img[hcp_pkg::IDX_PID_LO]};
			next_st.rel_hi = st.img[hcp_pkg::IDX_REL_HI];
		end else begin
			next_st.vid = DEF_VID;
			next_st.pid = DEF_PID;
			next_st.rel_hi = DEF_REL_HI;
		end

		next_st.fs_restrict = flags[hcp_pkg::FLG_FS];
		hs = i_hs_attached && !flags[hcp_pkg::FLG_FS];

		// upstream budget and controller current by speed and supply
		case (st.fmt)
			hcp_pkg::FMT_EXT: begin
				next_st.budget = hs ? st.img[hcp_pkg::IDX_EXT_MAXPWR_HS]
					: st.img[hcp_pkg::IDX_EXT_MAXPWR_FS];
				if (i_self_powered) begin
					next_st.ctrl_cur = hs ? st.img[hcp_pkg::IDX_EXT_CC_HS_SELF]
						: st.img[hcp_pkg::IDX_EXT_CC_FS_SELF];
				end else begin
					next_st.ctrl_cur = hs ? st.img[hcp_pkg::IDX_EXT_CC_HS_BUS]
						: st.img[hcp_pkg::IDX_EXT_CC_FS_BUS];
				end
			end
			hcp_pkg::FMT_MID: begin
				next_st.budget = st.img[hcp_pkg::IDX_MID_MAXPWR];
				next_st.ctrl_cur = st.img[hcp_pkg::IDX_MID_CC];
			end
			default: begin
				next_st.budget = hs ? hcp_pkg::DEF_MAXPWR_HS
					: hcp_pkg::DEF_MAXPWR_FS;
				if (!hs) begin
					next_st.ctrl_cur = hcp_pkg::DEF_CC_FS;
				end else if (i_self_powered) begin
					next_st.ctrl_cur = hcp_pkg::DEF_CC_HS_SELF;
				end else begin
					next_st.ctrl_cur = hcp_pkg::DEF_CC_HS_BUS;
				end
			end
		endcase

		// port masks by layout
		if (st.fmt == hcp_pkg::FMT_EXT) begin
			usable = st.img[hcp_pkg::IDX_EXT_USABLE][3:0];
			detach_log = st.img[hcp_pkg::IDX_EXT_DETACH][3:0];
		end else if (st.fmt == hcp_pkg::FMT_MID) begin
			usable = st.img[hcp_pkg::IDX_MID_PORTS][7:4];
			detach_log = st.img[hcp_pkg::IDX_MID_PORTS][3:0];
		end else begin
			usable = hcp_pkg::DEF_PORTS;
			detach_log = hcp_pkg::DEF_PORTS;
		end
		lcnt = 3'h0;
		next_st.detach_phys = 4'h0;
		for (int p = 0; p < 4; p++) begin
			if (usable[p]) begin
				next_st.detach_phys[p] = detach_log[lcnt[1:0]];
				lcnt = lcnt + 3'h1;
			end
		end
		next_st.port_count = lcnt;

		// string pointer base, strings off when count out of range
		if (st.fmt == hcp_pkg::FMT_EXT
			&& st.img[hcp_pkg::IDX_EXT_LANGS] != 8'h00
			&& st.img[hcp_pkg::IDX_EXT_LANGS] <= {3'h0, hcp_pkg::MAX_LANGS}) begin
			next_st.langs = st.img[hcp_pkg::IDX_EXT_LANGS][4:0];
			next_st.bitmap = st.img[hcp_pkg::IDX_EXT_BITMAP];
		end else begin
			next_st.langs = 5'h0;
			next_st.bitmap = 8'h00;
		end
		next_st.mfr_base = hcp_pkg::IDX_LANG_TABLE
			+ {5'h0, next_st.langs, 1'b0};

		next_st.hub_char = 16'h0;
		next_st.hub_char[1:0] = flags[hcp_pkg::FLG_GANG] ? 2'b00 : 2'b01;
		next_st.hub_char[4:3] = flags[hcp_pkg::FLG_GANG] ? 2'b00 : 2'b01;
		next_st.hub_char[hcp_pkg::HC_COMBINED] = flags[hcp_pkg::FLG_COMBINED];
		next_st.hub_char[hcp_pkg::HC_IND] = !flags[hcp_pkg::FLG_IND];

		if (flags[hcp_pkg::FLG_GANG]) begin
			next_st.port_pwr = {4{|(i_port_pwr_req & usable)}} & usable;
		end else begin
			next_st.port_pwr = i_port_pwr_req & usable;
		end
		next_st.ind = flags[hcp_pkg::FLG_IND] ? 4'h0 : (i_ind_req & usable);

		if (i_desc_req) begin
			if (i_desc_type == hcp_pkg::DESC_TYPE_HUB
				|| (i_desc_type == hcp_pkg::DESC_TYPE_ZERO
				&& flags[hcp_pkg::FLG_ACCEPT_ZERO])) begin
				next_st.desc_ok = 1'b1;
			end else begin
				next_st.desc_stall = 1'b1;
			end
		end

		// register writes
		if (i_reg_wr && i_reg_addr == hcp_pkg::REG_CTRL
			&& i_reg_wdata[hcp_pkg::CTRL_RELOAD]) begin
			next_st.reload = 1'b1;
		end
		// register reads, answer one cycle later
		if (i_reg_rd) begin
			if (i_reg_addr == hcp_pkg::REG_STATUS) begin
				next_st.rdata = {25'h0, st.fmt, st.vendor_mode,
					st.connect_en, st.reload, st.state};
			end else if (i_reg_addr == hcp_pkg::REG_IDS) begin
				next_st.rdata = {st.pid, st.vid};
			end else if (i_reg_addr == hcp_pkg::REG_POWER) begin
				next_st.rdata = {st.rel_hi, st.ctrl_cur, st.budget, st.pwron};
			end else if (i_reg_addr == hcp_pkg::REG_PORTS) begin
				next_st.rdata = {st.bitmap, st.hub_char[7:0], 5'h0,
					st.port_count, st.detach_phys, o_oc_flag};
			end else begin
				next_st.rdata = 32'h0;
			end
		end
	end

	// state register; load starts on reset release
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.reload <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign o_rd_req = st.rd_req;
	assign o_rd_addr = {6'h0, st.addr};
	assign o_reg_rdata = st.rdata;
	assign o_desc_ok = st.desc_ok;
	assign o_desc_stall = st.desc_stall;
	assign o_port_pwr = st.port_pwr;
	assign o_ind = st.ind;
	assign o_connect_en = st.connect_en;
	assign o_vendor_mode = st.vendor_mode;
	assign o_fs_restrict = st.fs_restrict;
	assign o_power_good_delay = st.pwron;
	assign o_hub_char = st.hub_char;
	assign o_vid = st.vid;
	assign o_pid = st.pid;
	assign o_release_hi = st.rel_hi;
	assign o_upstream_current_budget = st.budget;
	assign o_controller_current = st.ctrl_cur;
	assign o_port_count = st.port_count;
	assign o_detachable_phys = st.detach_phys;
	assign o_language_count = st.langs;
	assign o_string_bitmap = st.bitmap;
	assign o_mfr_ptr_base = st.mfr_base;
endmodule : hcp_config_loader

// file: logic/hcp_pkg.sv
// shared constants and types for the hub configuration loader
package hcp_pkg;
	// image format codes held in byte 0
	localparam logic [7:0] CODE_MIN = 8'hd0;
	localparam logic [7:0] CODE_MID = 8'hd2;
	localparam logic [7:0] CODE_EXT = 8'hd4;
	localparam logic [7:0] CODE_ERASED = 8'hff;
	// byte indices common to every layout; byte 7 is not fetched in the minimum layout
	localparam logic [4:0] IDX_CODE = 5'h00;
	localparam logic [4:0] IDX_VID_LO = 5'h01;
	localparam logic [4:0] IDX_VID_HI = 5'h02;
	localparam logic [4:0] IDX_PID_LO = 5'h03;
	localparam logic [4:0] IDX_PID_HI = 5'h04;
	localparam logic [4:0] IDX_REL_HI = 5'h06;
	localparam logic [4:0] IDX_OC = 5'h07;
	// shorter layout
	localparam logic [4:0] IDX_MID_PORTS = 5'h08;
	localparam logic [4:0] IDX_MID_MAXPWR = 5'h09;
	localparam logic [4:0] IDX_MID_CC = 5'h0a;
	localparam logic [4:0] IDX_MID_PWRON = 5'h0b;
	localparam logic [4:0] IDX_MID_FLAGS = 5'h0c;
	// extended layout
	localparam logic [4:0] IDX_EXT_MAXPWR_FS = 5'h08;
	localparam logic [4:0] IDX_EXT_MAXPWR_HS = 5'h09;
	localparam logic [4:0] IDX_EXT_CC_FS_BUS = 5'h0c;
	localparam logic [4:0] IDX_EXT_CC_HS_BUS = 5'h0d;
	localparam logic [4:0] IDX_EXT_CC_FS_SELF = 5'h0e;
	localparam logic [4:0] IDX_EXT_CC_HS_SELF = 5'h0f;
	localparam logic [4:0] IDX_EXT_PWRON = 5'h10;
	localparam logic [4:0] IDX_EXT_FLAGS = 5'h11;
	localparam logic [4:0] IDX_EXT_LANGS = 5'h14;
	localparam logic [4:0] IDX_EXT_BITMAP = 5'h15;
	localparam logic [4:0] IDX_EXT_USABLE = 5'h16;
	localparam logic [4:0] IDX_EXT_DETACH = 5'h17;
	localparam logic [10:0] IDX_LANG_TABLE = 11'h018;
	// last byte fetched per layout
	localparam logic [4:0] LAST_MIN = 5'h06;
	localparam logic [4:0] LAST_MID = 5'h0c;
	localparam logic [4:0] LAST_EXT = 5'h17;
	localparam int IMG_BYTES = 24;
	// default values of the loaded fields
	localparam logic [7:0] DEF_PWRON = 8'h32;
	localparam logic [7:0] DEF_FLAGS = 8'h80;
	localparam logic [7:0] DEF_OC = 8'h88;
	localparam logic [7:0] DEF_MAXPWR_FS = 8'h28;
	localparam logic [7:0] DEF_MAXPWR_HS = 8'h57;
	localparam logic [7:0] DEF_CC_FS = 8'h50;
	localparam logic [7:0] DEF_CC_HS_BUS = 8'hae;
	localparam logic [7:0] DEF_CC_HS_SELF = 8'h64;
	localparam logic [3:0] DEF_PORTS = 4'hf;
	localparam logic [4:0] MAX_LANGS = 5'h1f;
	// flag byte bit positions
	localparam int FLG_ACCEPT_ZERO = 7;
	localparam int FLG_COMBINED = 6;
	localparam int FLG_FS = 5;
	localparam int FLG_IND = 4;
	localparam int FLG_GANG = 2;
	// hub characteristics bit positions
	localparam int HC_COMBINED = 2;
	localparam int HC_IND = 7;
	// descriptor types
	localparam logic [7:0] DESC_TYPE_HUB = 8'h29;
	localparam logic [7:0] DESC_TYPE_ZERO = 8'h00;
	// register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_IDS = 4'h2;
	localparam logic [3:0] REG_POWER = 4'h3;
	localparam logic [3:0] REG_PORTS = 4'h4;
	localparam int CTRL_RELOAD = 0;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
	// load sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ = 2'b01,
		ST_WAIT = 2'b10,
		ST_DONE = 2'b11
	} hcp_load_state_type;
	// layout found in the image
	typedef enum logic [1:0] {
		FMT_NONE = 2'b00,
		FMT_MIN = 2'b01,
		FMT_MID = 2'b10,
		FMT_EXT = 2'b11
	} hcp_fmt_type;
endpackage : hcp_pkg

// file: logic/hcp_sync2.sv
// two-flop synchroniser for a vector of pin levels
module hcp_sync2 #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// pin side
	input wire logic [W-1:0] i_async,
	// clock side
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} hcp_sync_state_type;

	hcp_sync_state_type st;
	hcp_sync_state_type next_st;

	// first stage feeds only the second
	always_comb begin
		next_st.stage1 = i_async;
		next_st.stage2 = st.stage1;
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_sync = st.stage2;
endmodule : hcp_sync2

// file: logic/hcp_oc_filter.sv
// millisecond filter for one overcurrent input
module hcp_oc_filter (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// timing and limits
	input wire logic i_tick_ms,
	input wire logic i_enabled,
	input wire logic [3:0] i_limit_active,
	input wire logic [3:0] i_limit_idle,
	// overcurrent level and filtered flag
	input wire logic i_oc,
	output logic o_oc_flag
);
	typedef struct packed {
		logic [3:0] cnt;
		logic flag;
	} hcp_ocf_state_type;

	hcp_ocf_state_type st;
	hcp_ocf_state_type next_st;
	logic [3:0] limit;

	// count whole ms while the level stands, flag at the limit
	always_comb begin
		next_st = st;
		limit = i_enabled ? i_limit_active : i_limit_idle;
		if (!i_oc) begin
			next_st.cnt = 4'h0;
			next_st.flag = 1'b0;
		end else if (st.cnt >= limit) begin
			next_st.flag = 1'b1;
		end else if (i_tick_ms) begin
			next_st.cnt = st.cnt + 4'h1;
		end
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_oc_flag = st.flag;
endmodule : hcp_oc_filter

// file: tb/hcp_loader_sva.sv
// port assertions for the hub configuration loader
module hcp_loader_sva #(
	parameter int MS_CYCLES = 10
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// image reader
	input wire logic o_rd_req,
	input wire logic [10:0] o_rd_addr,
	input wire logic i_rd_valid,
	// register port
	input wire logic i_reg_rd,
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] o_reg_rdata,
	// descriptor check
	input wire logic i_desc_req,
	input wire logic [7:0] i_desc_type,
	input wire logic o_desc_ok,
	input wire logic o_desc_stall,
	// ports and decoded fields
	input wire logic [3:0] i_port_oc,
	input wire logic [3:0] o_oc_flag,
	input wire logic [3:0] o_ind,
	input wire logic o_connect_en,
	input wire logic [15:0] o_hub_char,
	input wire logic [15:0] o_vid,
	input wire logic [15:0] o_pid,
	input wire logic [4:0] o_language_count,
	input wire logic [10:0] o_mfr_ptr_base
);
	logic [2:0] up;
	// cycles since reset release, saturating; masks the default phase
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n || up != 3'h7);
	AST_RD_HOLD: assert property (
		o_rd_req && !i_rd_valid |=> o_rd_req && $stable(o_rd_addr))
		else $error("read request dropped or address moved");
	AST_RD_DROP: assert property (
		o_rd_req && i_rd_valid |=> !o_rd_req)
		else $error("read request kept after byte taken");
	AST_CONNECT: assert property (
		$rose(o_connect_en) |-> !o_rd_req)
		else $error("connect enabled while image read pending");
	AST_DESC_HUB: assert property (
		i_desc_req && i_desc_type == hcp_pkg::DESC_TYPE_HUB
		|=> o_desc_ok && !o_desc_stall)
		else $error("hub descriptor type not accepted");
	AST_DESC_BAD: assert property (
		i_desc_req && i_desc_type != 8'h29 && i_desc_type != 8'h00
		|=> o_desc_stall && !o_desc_ok)
		else $error("foreign descriptor type not stalled");
	AST_DESC_ZERO: assert property (
		i_desc_req && i_desc_type == 8'h00 |=> o_desc_ok != o_desc_stall)
		else $error("zero descriptor type gave no single answer");
	AST_IDS: assert property (
		i_reg_rd && i_reg_addr == hcp_pkg::REG_IDS
		|=> o_reg_rdata[15:0] == $past(o_vid) && o_reg_rdata[31:16] == $past(o_pid))
		else $error("id register differs from id outputs");
	AST_IND_OFF: assert property (
		!o_hub_char[7] && $stable(o_hub_char) |-> o_ind == 4'h0)
		else $error("indicator driven while suppressed");
	AST_GANG: assert property (
		o_hub_char[4:3] == o_hub_char[1:0] && !o_hub_char[1])
		else $error("power switching fields inconsistent");
	AST_MFR: assert property (
		o_mfr_ptr_base == 11'd24 + {5'h0, o_language_count, 1'b0})
		else $error("manufacturer pointer base wrong");
	AST_OC_CLR: assert property (
		!i_port_oc[0] [*4] |=> !o_oc_flag[0])
		else $error("overcurrent flag outlives its input");
endmodule : hcp_loader_sva

// file: tb/hcp_eeprom_model.sv
// behavioural serial memory answering image byte reads
module hcp_eeprom_model (
	// clock
	input wire logic i_clk_sys,
	// byte request
	input wire logic i_rd_req,
	input wire logic [10:0] i_rd_addr,
	input wire logic i_slow,
	// answer
	output logic o_rd_valid,
	output logic [7:0] o_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:31];
	logic [3:0] cnt = 4'h0;
	logic sent = 1'b0;
	initial o_rd_valid = 1'b0;
	initial o_rd_data = 8'h00;
	// one byte per request; data toggles whenever not valid
	always @(posedge i_clk_sys) begin
		o_rd_valid <= 1'b0;
		o_rd_data <= ~o_rd_data;
		if (!i_rd_req) begin
			cnt <= 4'h0;
			sent <= 1'b0;
		end else if (!sent && cnt >= (i_slow ? 4'h6 : 4'h0)) begin
			o_rd_valid <= 1'b1;
			o_rd_data <= mem[i_rd_addr[4:0]];
			sent <= 1'b1;
		end else
			cnt <= cnt + 4'h1;
	end
endmodule : hcp_eeprom_model

// file: tb/tb.sv
// self-checking testbench for the hub configuration loader
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, arst_n = 1'b0, slow = 1'b1;
	logic rd_req, rd_valid, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [10:0] rd_addr, mfr;
	logic [7:0] rd_data, desc_type = 8'h0, pgd, rel, budget, ctrl, bmap;
	logic [3:0] reg_addr = 4'h0, pen = 4'h0, preq = 4'h0, ireq = 4'h0;
	logic [3:0] poc = 4'h0, oc, ppwr, ind, det;
	logic [31:0] wdata = 32'h0, rdata;
	logic hs = 1'b0, selfp = 1'b0, dreq = 1'b0, ok, stall, conn, vend, fso;
	logic [15:0] hc, vid, pid;
	logic [2:0] pcnt;
	logic [4:0] lcnt;
	int n_mismatch = 0;
	int tests_run = 0;
	always #10 clk = ~clk;
	hcp_config_loader #(.MS_CYCLES(10)) hcp_config_loader_inst (
		.i_clk_sys(clk), .i_arst_n(arst_n), .o_rd_req(rd_req),
		.o_rd_addr(rd_addr), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
		.i_reg_addr(reg_addr), .i_reg_wdata(wdata), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_hs_attached(hs),
		.i_self_powered(selfp), .i_port_enabled(pen), .i_port_pwr_req(preq),
		.i_ind_req(ireq), .i_desc_req(dreq), .i_desc_type(desc_type),
		.o_desc_ok(ok), .o_desc_stall(stall), .i_port_oc(poc), .o_oc_flag(oc),
		.o_port_pwr(ppwr), .o_ind(ind), .o_connect_en(conn),
		.o_vendor_mode(vend), .o_fs_restrict(fso), .o_power_good_delay(pgd),
		.o_hub_char(hc), .o_vid(vid), .o_pid(pid), .o_release_hi(rel),
		.o_upstream_current_budget(budget), .o_controller_current(ctrl),
		.o_port_count(pcnt), .o_detachable_phys(det),
		.o_language_count(lcnt), .o_string_bitmap(bmap),
		.o_mfr_ptr_base(mfr));
	hcp_eeprom_model hcp_eeprom_model_inst (.i_clk_sys(clk),
		.i_rd_req(rd_req), .i_rd_addr(rd_addr), .i_slow(slow),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : reg_read
	task automatic desc(input logic [7:0] t, input logic [1:0] exp);
		@(posedge clk);
		desc_type <= t;
		dreq <= 1'b1;
		@(posedge clk);
		dreq <= 1'b0;
		#1 chk({ok, stall}, exp);
	endtask : desc
	// image content written by the image preparer
	task automatic set_img(input logic [7:0] code, input logic [7:0] flags);
		for (int i = 0; i < 32; i++)
			hcp_eeprom_model_inst.mem[i] = 8'h10 + 8'(i);
		hcp_eeprom_model_inst.mem[0] = code;
		hcp_eeprom_model_inst.mem[7] = 8'h21;
		if (code == hcp_pkg::CODE_EXT) begin
			hcp_eeprom_model_inst.mem[10] = 8'h00;
			hcp_eeprom_model_inst.mem[11] = 8'h00;
			hcp_eeprom_model_inst.mem[17] = flags;
			hcp_eeprom_model_inst.mem[20] = 8'h03;
			hcp_eeprom_model_inst.mem[22] = 8'h0f;
		end else begin
			hcp_eeprom_model_inst.mem[8] = 8'hf0;
			hcp_eeprom_model_inst.mem[12] = flags;
		end
	endtask : set_img
	function automatic logic flag_of(input int sel);
		case (sel)
			0: return conn;
			1: return vend;
			default: return oc[1];
		endcase
	endfunction : flag_of
	// bounded wait for a completion flag
	task automatic wait_on(input int sel);
		int i;
		for (i = 0; i < 2000 && flag_of(sel) !== 1'b1; i++)
			@(posedge clk);
		if (i == 2000) begin
			n_mismatch++;
			finish_test();
		end
	endtask : wait_on
	task automatic reload();
		reg_write(hcp_pkg::REG_CTRL, 32'h1);
		tick(3);
		wait_on(0);
	endtask : reload
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// main sequence: extended, shorter, speed-limited, erased images
	initial begin
		set_img(hcp_pkg::CODE_EXT, 8'h44);
		tick(6);
		arst_n <= 1'b1;
		wait_on(0);
		chk({pid, vid}, 32'h14131211);
		chk(rel, 8'h16);
		chk(pgd, 8'h20);
		chk(hc[7:0], 8'h84);
		chk(mfr, 11'd30);
		chk({lcnt, bmap}, {5'd3, 8'h25});
		reg_read(hcp_pkg::REG_POWER, 32'h161c1820);
		reg_write(hcp_pkg::REG_IDS, 32'hffffffff);
		reg_read(hcp_pkg::REG_IDS, 32'h14131211);
		reg_read(4'hf, 32'h0);
		desc(8'h00, 2'b01);
		desc(8'h29, 2'b10);
		desc(8'h05, 2'b01);
		tick(1);
		for (int k = 0; k < 4; k++) begin
			hs <= k[1];
			selfp <= k[0];
			tick(2);
			chk(budget, k[1] ? 8'h19 : 8'h18);
			chk(ctrl, 8'h1c + {6'h0, k[0], k[1]});
		end
		preq <= 4'h1;
		ireq <= 4'ha;
		pen <= 4'h1;
		poc <= 4'h3;
		tick(2);
		chk(oc, 4'h0);
		chk(ppwr, 4'hf);
		chk(ind, 4'ha);
		wait_on(2);
		chk(oc[1:0], 2'b10);
		tick(30);
		chk(oc[1:0], 2'b11);
		poc <= 4'h0;
		tick(6);
		chk(oc, 4'h0);
		$display("test extended layout done");
		slow <= 1'b0;
		set_img(hcp_pkg::CODE_MID, 8'hb0);
		reload();
		chk(pgd, 8'h1b);
		chk({budget, ctrl}, 16'h191a);
		chk(fso, 1'b1);
		chk(hc[7:0], 8'h09);
		chk(ind, 4'h0);
		chk(pcnt, 3'd4);
		desc(8'h00, 2'b10);
		tick(1);
		preq <= 4'h5;
		tick(3);
		chk(ppwr, 4'h5);
		$display("test shorter layout done");
		set_img(hcp_pkg::CODE_EXT, 8'h20);
		hcp_eeprom_model_inst.mem[22] = 8'h09;
		hcp_eeprom_model_inst.mem[23] = 8'h02;
		reload();
		chk({budget, ctrl}, 16'h181e);
		chk({pcnt, det}, {3'd2, 4'h8});
		chk(hc[7:0], 8'h89);
		reg_read(hcp_pkg::REG_PORTS, 32'h25890280);
		$display("test full speed only done");
		set_img(8'hff, 8'h00);
		reg_write(hcp_pkg::REG_CTRL, 32'h1);
		wait_on(1);
		chk(vend, 1'b1);
		chk(pgd, 8'h32);
		reg_read(hcp_pkg::REG_STATUS, 32'h1b);
		desc(8'h00, 2'b10);
		$display("test erased image done");
		finish_test();
	end
endmodule : tb
bind hcp_config_loader hcp_loader_sva #(.MS_CYCLES(MS_CYCLES)) sva_inst (
	.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .o_rd_req(o_rd_req),
	.o_rd_addr(o_rd_addr), .i_rd_valid(i_rd_valid), .i_reg_rd(i_reg_rd),
	.i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
	.i_desc_req(i_desc_req), .i_desc_type(i_desc_type),
	.o_desc_ok(o_desc_ok), .o_desc_stall(o_desc_stall),
	.i_port_oc(i_port_oc), .o_oc_flag(o_oc_flag), .o_ind(o_ind),
	.o_connect_en(o_connect_en), .o_hub_char(o_hub_char), .o_vid(o_vid),
	.o_pid(o_pid), .o_language_count(o_language_count),
	.o_mfr_ptr_base(o_mfr_ptr_base));
